/* File: hw/sfl_cfg.svh */
// sfl_cfg.svh: register layout, reset values and command codes of the configuration logic
// assumes: included by its bare name from the config, host model and test modules
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH
`define SFL_BIT_LC_HI      7
`define SFL_BIT_LC_LO      6
`define SFL_BIT_PROT_START 5
`define SFL_BIT_RSVD       4
`define SFL_BIT_PROT_VOL   3
`define SFL_BIT_PARAM      2
`define SFL_BIT_QUAD       1
`define SFL_BIT_FREEZE     0
`define SFL_CR1_RESET      8'h00
`define SFL_BP_VOL_RESET   3'h7
`define SFL_BP_RESET       3'h0
`define SFL_CMD_WRITE_REGS 8'h01
`define SFL_CMD_READ_CFG   8'h35
`define SFL_OTP_MASK       8'h2C
`define SFL_RSVD_MASK      8'hEF
`define SFL_WRITE_BITS     5'h10
`endif

/* File: hw/sfl_pkg.sv */
// sfl_pkg.sv: types shared by the configuration logic
// assumes: nothing beyond the cfg header
package sfl_pkg;
    typedef enum logic [3:0] {
        RD_FAST     = 4'h0,
        RD_DUAL_OUT = 4'h1,
        RD_QUAD_OUT = 4'h2,
        RD_DUAL_IO  = 4'h3,
        RD_QUAD_IO  = 4'h4,
        RD_DDR_FAST = 4'h5,
        RD_DDR_DUAL = 4'h6,
        RD_DDR_QUAD = 4'h7,
        RD_PLAIN    = 4'h8
    } sfl_read_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CMD  = 2'h1,
        ST_DATA = 2'h2,
        ST_OUT  = 2'h3
    } sfl_state_t;
endpackage : sfl_pkg

/* File: hw/sfl_lat_if.sv */
// sfl_lat_if.sv: latency lookup carrier between top and lookup module
// assumes: single clock domain of the link side
`timescale 1ns/1ps
`default_nettype none
interface sfl_lat_if;
    logic [1:0]        code;
    sfl_pkg::sfl_read_t cmd;
    logic [2:0]        mode;
    logic [3:0]        dummy;
    modport user (output code, output cmd, input mode, input dummy);
    modport table_side (input code, input cmd, output mode, output dummy);
endinterface : sfl_lat_if
`default_nettype wire

/* File: hw/sfl_lat_table.sv */
// sfl_lat_table.sv: mode and dummy cycle counts per read command and latency code
// assumes: variant fixed at elaboration, code comes from the configuration register
`timescale 1ns/1ps
`default_nettype none
module sfl_lat_table #(
    parameter bit ENHANCED = 1'b0
) (
    sfl_lat_if.table_side lat
);
    always_comb begin
        lat.mode  = 3'h0;
        lat.dummy = 4'h0;
        unique case (lat.cmd)
            sfl_pkg::RD_PLAIN: begin
                lat.dummy = 4'h0; // RULE6
            end
            sfl_pkg::RD_FAST, sfl_pkg::RD_DUAL_OUT, sfl_pkg::RD_QUAD_OUT: begin
                lat.dummy = (lat.code == 2'h3) ? 4'h0 : 4'h8; // RULE1
            end
            sfl_pkg::RD_DUAL_IO: begin
                if (ENHANCED) begin
                    lat.mode = 3'h4; // RULE4
                    unique case (lat.code)
                        2'h3: lat.dummy = 4'h0;
                        2'h0: lat.dummy = 4'h0;
                        2'h1: lat.dummy = 4'h1;
                        2'h2: lat.dummy = 4'h2;
                    endcase
                end else begin
                    unique case (lat.code) // RULE2
                        2'h3: lat.dummy = 4'h4;
                        2'h0: lat.dummy = 4'h4;
                        2'h1: lat.dummy = 4'h5;
                        2'h2: lat.dummy = 4'h6;
                    endcase
                end
            end
            sfl_pkg::RD_QUAD_IO: begin
                lat.mode = 3'h2; // RULE2
                unique case (lat.code)
                    2'h3: lat.dummy = 4'h1;
                    2'h0: lat.dummy = 4'h4;
                    2'h1: lat.dummy = 4'h4;
                    2'h2: lat.dummy = 4'h5;
                endcase
            end
            sfl_pkg::RD_DDR_FAST: begin
                lat.mode = ENHANCED ? 3'h4 : 3'h0; // RULE5
                unique case (lat.code) // RULE3
                    2'h3: lat.dummy = ENHANCED ? 4'h1 : 4'h4;
                    2'h0: lat.dummy = ENHANCED ? 4'h2 : 4'h5;
                    2'h1: lat.dummy = ENHANCED ? 4'h4 : 4'h6;
                    2'h2: lat.dummy = ENHANCED ? 4'h5 : 4'h7;
                endcase
            end
            sfl_pkg::RD_DDR_DUAL: begin
                lat.mode = ENHANCED ? 3'h2 : 3'h0; // RULE5
                unique case (lat.code) // RULE3
                    2'h3: lat.dummy = ENHANCED ? 4'h2 : 4'h4;
                    2'h0: lat.dummy = ENHANCED ? 4'h4 : 4'h6;
                    2'h1: lat.dummy = ENHANCED ? 4'h5 : 4'h7;
                    2'h2: lat.dummy = ENHANCED ? 4'h6 : 4'h8;
                endcase
            end
            sfl_pkg::RD_DDR_QUAD: begin
                lat.mode = 3'h1; // RULE3
                unique case (lat.code)
                    2'h3: lat.dummy = 4'h3;
                    2'h0: lat.dummy = 4'h6;
                    2'h1: lat.dummy = 4'h7;
                    2'h2: lat.dummy = 4'h8;
                endcase
            end
            default: begin
                lat.mode  = 3'h0;
                lat.dummy = 4'h0;
            end
        endcase
    end
endmodule : sfl_lat_table
`default_nettype wire

/* File: hw/sfl_config.sv */
// sfl_config.sv: configuration register one of a serial flash, with its serial
// write/read path, latency decode, protection and quad-pin handling.
// assumes: sclk_i is the serial clock, only toggling while chip select is low;
// command decode is a bare opcode byte on data line zero, msb first.
//
// How it works
// RULE1: plain SDR reads: eight dummies, none for 11
// RULE2: dual/quad I/O standard SDR dummy tables
// RULE3: standard DDR mode and dummy tables
// RULE4: enhanced dual I/O: four mode cycles
// RULE5: enhanced DDR mode and dummy tables
// RULE6: host: plain read only to 50 MHz
// RULE7: host: code 10 frequency limits respected
// RULE8: host: no read at undefined rates
// RULE9: lower clock always reads correctly
// RULE10: learning pattern fills last four dummies
// RULE11: host: recommended codes with learning pattern
// RULE12: placement bit picks protection start end
// RULE13: one-time bits never return to zero
// RULE14: volatile protect bits reload all ones
// RULE15: parameter bit places small sectors top/bottom
// RULE16: uniform sectors ignore parameter bit
// RULE17: host: set placement bits before programming
// RULE18: quad makes protect/hold pins data lines
// RULE19: host: set quad before quad commands
// RULE20: freeze blocks protect and placement writes
// RULE21: freeze survives soft reset only
// RULE22: unfrozen register writable, freeze together
// RULE23: latency field selects mode/dummy counts
// RULE24: host: write-registers and read-config commands
// RULE25: variant fixed at manufacture
// RULE26: variant is an elaboration parameter
`timescale 1ns/1ps
`default_nettype none
`include "sfl_cfg.svh"
module sfl_config #(
    parameter bit ENHANCED = 1'b0,
    parameter bit UNIFORM  = 1'b0
) (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       soft_reset_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       data_line_zero_i,
    output logic            data_line_one_o,
    output logic            data_line_one_oe_o,
    input  wire logic       wp_n_i,
    input  wire logic       hold_n_i,
    input  wire logic [3:0] read_cmd_i,
    input  wire logic       ddr_learning_pattern_i,
    input  wire logic [3:0] dummy_index_i,
    output logic [2:0]      mode_cycles_o,
    output logic [3:0]      dummy_cycles_o,
    output logic            pattern_drive_o,
    output logic [7:0]      config_reg_one_o,
    output logic [2:0]      block_protect_bits_o,
    output logic            protect_from_zero_o,
    output logic            param_at_top_o,
    output logic            program_error_o,
    output logic            quad_mode_o,
    output logic            wp_active_o,
    output logic            hold_active_o
);
    // link-side state, all on the serial clock
    typedef struct packed {
        sfl_pkg::sfl_state_t st;
        logic [4:0]          cnt;
        logic [15:0]         shift;
        logic [7:0]          out_sr;
        logic                wr_tgl;
        logic [7:0]          wr_sr;
        logic [7:0]          wr_cr;
        logic                drive;
    } sfl_link_t;

    // core-side state on the reference clock
    typedef struct packed {
        logic [7:0] cr;
        logic [2:0] bp;
        logic       perr;
        logic [2:0] tgl_sync;
        logic [1:0] wp_sync;
        logic [1:0] hold_sync;
    } sfl_core_t;

    sfl_link_t lk_q, lk_d, lk_c;
    sfl_core_t co_q, co_d;
    logic        frame_q;
    logic [7:0]  lk_cr_s1_q;
    logic [7:0]  lk_cr_s2_q;
    logic [7:0]  cr_link;
    logic [7:0]  cr_new;
    logic [7:0]  req_sr;
    logic [7:0]  req_cr;
    logic        wr_event;
    sfl_lat_if   lat ();

    // core register copy carried to the link domain; the register only changes
    // some core cycles after the last edge of a write frame, so no tear is seen
    always_ff @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lk_cr_s1_q <= 8'h00;
            lk_cr_s2_q <= 8'h00;
        end else begin
            lk_cr_s1_q <= co_q.cr;
            lk_cr_s2_q <= lk_cr_s1_q;
        end
    end
    assign cr_link = lk_cr_s2_q;

    always_comb begin
        // the serial clock stops while chip select is high, so a frame starts clean
        lk_c = lk_q;
        if (!frame_q) begin
            lk_c.st    = sfl_pkg::ST_IDLE;
            lk_c.cnt   = 5'h00;
            lk_c.drive = 1'b0;
        end
        lk_d = lk_c;
        unique case (lk_c.st)
            sfl_pkg::ST_IDLE, sfl_pkg::ST_CMD: begin
                lk_d.st    = sfl_pkg::ST_CMD;
                lk_d.shift = {lk_c.shift[14:0], data_line_zero_i};
                lk_d.cnt   = lk_c.cnt + 5'h01;
                if (lk_c.cnt == 5'h07) begin
                    lk_d.cnt = 5'h00;
                    if ({lk_c.shift[6:0], data_line_zero_i} == `SFL_CMD_WRITE_REGS) begin
                        lk_d.st = sfl_pkg::ST_DATA; // RULE24
                    end else if ({lk_c.shift[6:0], data_line_zero_i} == `SFL_CMD_READ_CFG) begin
                        lk_d.st     = sfl_pkg::ST_OUT;
                        lk_d.out_sr = cr_link;
                        lk_d.drive  = 1'b1;
                    end else begin
                        lk_d.st = sfl_pkg::ST_IDLE;
                    end
                end
            end
            sfl_pkg::ST_DATA: begin
                lk_d.shift = {lk_c.shift[14:0], data_line_zero_i};
                lk_d.cnt   = lk_c.cnt + 5'h01;
                if (lk_c.cnt == `SFL_WRITE_BITS - 5'h01) begin
                    // sixteen cycles: status byte then configuration byte
                    lk_d.wr_sr  = lk_c.shift[14:7];
                    lk_d.wr_cr  = {lk_c.shift[6:0], data_line_zero_i};
                    lk_d.wr_tgl = ~lk_c.wr_tgl;
                    lk_d.st     = sfl_pkg::ST_IDLE;
                    lk_d.cnt    = 5'h00;
                end
            end
            sfl_pkg::ST_OUT: begin
                lk_d.drive  = 1'b1;
                lk_d.out_sr = {lk_c.out_sr[6:0], lk_c.out_sr[7]};
            end
        endcase
    end

    // chip select high ends the frame; the toggle and captured bytes survive it
    always_ff @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lk_q <= '0;
        end else if (cs_n_i) begin
            lk_q.st    <= sfl_pkg::ST_IDLE;
            lk_q.cnt   <= 5'h00;
            lk_q.drive <= 1'b0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // low until the first serial edge of a frame; a cut frame leaves no stale state
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_q <= 1'b0;
        end else if (cs_n_i) begin
            frame_q <= 1'b0;
        end else begin
            frame_q <= 1'b1;
        end
    end

    assign data_line_one_o    = lk_q.out_sr[7];
    assign data_line_one_oe_o = lk_q.drive & frame_q & ~cs_n_i;

    assign wr_event = co_q.tgl_sync[2] ^ co_q.tgl_sync[1];
    assign req_sr   = lk_q.wr_sr;
    assign req_cr   = lk_q.wr_cr;

    always_comb begin
        co_d          = co_q;
        co_d.tgl_sync = {co_q.tgl_sync[1:0], lk_q.wr_tgl};
        co_d.wp_sync  = {co_q.wp_sync[0], wp_n_i};
        co_d.hold_sync = {co_q.hold_sync[0], hold_n_i};
        cr_new        = co_q.cr;
        // an error raised by a write in the same cycle as a soft reset is kept
        if (soft_reset_i) begin
            co_d.perr = 1'b0;
        end
        if (wr_event) begin
            // bytes are stable: the toggle moved two core edges ago
            if (!co_q.cr[`SFL_BIT_FREEZE]) begin
                cr_new = req_cr & `SFL_RSVD_MASK; // RULE22
                cr_new = cr_new | (co_q.cr & `SFL_OTP_MASK); // RULE13
                if ((co_q.cr & `SFL_OTP_MASK & ~req_cr) != 8'h00) begin
                    co_d.perr = 1'b1; // RULE13
                end
                co_d.bp = req_sr[4:2];
            end else begin
                // locked: only latency and quad still follow the write
                cr_new[7:6] = req_cr[7:6]; // RULE20
                cr_new[`SFL_BIT_QUAD] = req_cr[`SFL_BIT_QUAD];
            end
        end
        co_d.cr = cr_new;
        if (soft_reset_i) begin
            if (co_q.cr[`SFL_BIT_PROT_VOL]) begin
                co_d.bp = `SFL_BP_VOL_RESET; // RULE14
            end
        end
    end

    // power-on state: non-volatile bits are modelled as reset values here;
    // volatile protect bits cannot know the volatility strap until after release
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            co_q    <= '0;
            co_q.cr <= `SFL_CR1_RESET; // RULE21
            co_q.bp <= `SFL_BP_RESET;
        end else begin
            co_q <= co_d;
        end
    end

    assign lat.code = cr_link[`SFL_BIT_LC_HI:`SFL_BIT_LC_LO]; // RULE23
    assign lat.cmd  = sfl_pkg::sfl_read_t'(read_cmd_i);

    // RULE25 RULE26 RULE9
    sfl_lat_table #(
        .ENHANCED (ENHANCED)
    ) u_table (
        .lat (lat)
    );

    assign mode_cycles_o  = lat.mode;
    assign dummy_cycles_o = lat.dummy;

    // pattern in the last four dummy cycles when there are five or more, index counts from zero
    assign pattern_drive_o = ddr_learning_pattern_i && (lat.dummy >= 4'h5) && // RULE10
                             (dummy_index_i >= lat.dummy - 4'h4) &&
                             (dummy_index_i < lat.dummy);

    assign config_reg_one_o     = co_q.cr;
    assign block_protect_bits_o = co_q.bp;
    assign protect_from_zero_o  = co_q.cr[`SFL_BIT_PROT_START]; // RULE12
    assign param_at_top_o       = UNIFORM ? 1'b0 : co_q.cr[`SFL_BIT_PARAM]; // RULE15 RULE16
    assign program_error_o      = co_q.perr;
    assign quad_mode_o          = co_q.cr[`SFL_BIT_QUAD];
    // quad mode forces both pins inactive
    assign wp_active_o   = ~co_q.cr[`SFL_BIT_QUAD] & ~co_q.wp_sync[1]; // RULE18
    assign hold_active_o = ~co_q.cr[`SFL_BIT_QUAD] & ~co_q.hold_sync[1]; // RULE18
endmodule : sfl_config
`default_nettype wire

/* File: tb/sfl_config_properties.sv */
// sfl_config_properties.sv: port checks of the configuration logic
// assumes: bound to every sfl_config, core clock domain only
`timescale 1ns/1ps
`default_nettype none
module sfl_config_properties #(
    parameter bit UNIFORM = 1'b0
) (
    input wire logic       ref_clk_i,
    input wire logic       reset_n_i,
    input wire logic       soft_reset_i,
    input wire logic       ddr_learning_pattern_i,
    input wire logic [3:0] dummy_index_i,
    input wire logic [3:0] dummy_cycles_o,
    input wire logic       pattern_drive_o,
    input wire logic [7:0] config_reg_one_o,
    input wire logic [2:0] block_protect_bits_o,
    input wire logic       protect_from_zero_o,
    input wire logic       param_at_top_o,
    input wire logic       quad_mode_o,
    input wire logic       wp_active_o,
    input wire logic       hold_active_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_quad_pins;
        quad_mode_o && $past(quad_mode_o) |-> !wp_active_o && !hold_active_o;
    endproperty
    a_quad_pins: assert property (p_quad_pins) else $error("pin active in quad");
    property p_prot_start;
        protect_from_zero_o == config_reg_one_o[5];
    endproperty
    a_prot_start: assert property (p_prot_start) else $error("protect start wrong");
    property p_param;
        param_at_top_o == (config_reg_one_o[2] && !UNIFORM);
    endproperty
    a_param: assert property (p_param) else $error("param placement wrong");
    property p_otp;
        (config_reg_one_o & 8'h2C) != 8'h00 |=>
            (config_reg_one_o & $past(config_reg_one_o) & 8'h2C) == ($past(config_reg_one_o) & 8'h2C);
    endproperty
    a_otp: assert property (p_otp) else $error("one-time bit cleared");
    property p_freeze_hold;
        config_reg_one_o[0] |=>
            config_reg_one_o[0] && $stable(config_reg_one_o[5]) && $stable(config_reg_one_o[2]);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("frozen bits moved");
    // a soft reload of the protect bits is exempt for a short while
    property p_freeze_bp;
        config_reg_one_o[0] && !soft_reset_i && !$past(soft_reset_i) && !$past(soft_reset_i, 2)
            |=> $stable(block_protect_bits_o);
    endproperty
    a_freeze_bp: assert property (p_freeze_bp) else $error("frozen protect moved");
    property p_soft_vol;
        soft_reset_i && config_reg_one_o[3] |-> ##[1:3] block_protect_bits_o == 3'h7;
    endproperty
    a_soft_vol: assert property (p_soft_vol) else $error("volatile reload missing");
    property p_pattern;
        pattern_drive_o == (ddr_learning_pattern_i && dummy_cycles_o >= 4'h5
            && dummy_index_i >= dummy_cycles_o - 4'h4 && dummy_index_i < dummy_cycles_o);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern window wrong");
endmodule : sfl_config_properties
bind sfl_config sfl_config_properties #(.UNIFORM(UNIFORM)) u_sfl_config_properties (
    .ref_clk_i, .reset_n_i, .soft_reset_i, .ddr_learning_pattern_i, .dummy_index_i,
    .dummy_cycles_o, .pattern_drive_o, .config_reg_one_o, .block_protect_bits_o,
    .protect_from_zero_o, .param_at_top_o, .quad_mode_o, .wp_active_o, .hold_active_o);
`default_nettype wire

/* File: tb/sfl_host_model.sv */
// sfl_host_model.sv: serial host issuing register write and read frames
// assumes: mode 0 link, clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
`include "sfl_cfg.svh"
module sfl_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // 48 ns period stays below every rate limit of every latency code
    task automatic frame(input logic [23:0] bits, input int n, output logic [15:0] got);
        got = 16'h0000;
        #7.3 cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = bits[i];
            #24 sclk_o = 1'b1;
            #24 sclk_o = 1'b0;
            got = {got[14:0], miso_i};
        end
        #24 cs_n_o = 1'b1;
        // released line must not keep its last level
        mosi_o = ~mosi_o;
        #100;
    endtask : frame
    task automatic write_regs(input logic [7:0] status, input logic [7:0] cfg);
        logic [15:0] unused;
        frame({`SFL_CMD_WRITE_REGS, status, cfg}, 24, unused);
    endtask : write_regs
    task automatic read_cfg(output logic [7:0] cfg);
        logic [15:0] got;
        frame({8'h00, `SFL_CMD_READ_CFG, 8'h00}, 16, got);
        cfg = got[8:1];
    endtask : read_cfg
endmodule : sfl_host_model
`default_nettype wire

/* File: tb/sfl_config_test.sv */
// sfl_config_test.sv: self-checking bench, standard and enhanced variants side by side
// assumes: host model on the serial side, checker bound to each instance
`timescale 1ns/1ps
`default_nettype none
`include "sfl_cfg.svh"
`define CHECK(name, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("BAD %s expected %h seen %h", name, exp, got); \
    end \
end
module sfl_config_test;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [2:0]  ms;
        logic [15:0] ds;
        logic [2:0]  me;
        logic [15:0] de;
    } sfl_row_t;
    // dummy nibbles ordered by latency code 11, 10, 01, 00
    sfl_row_t   rows [9] = '{
        '{4'h0, 3'h0, 16'h0888, 3'h0, 16'h0888}, '{4'h1, 3'h0, 16'h0888, 3'h0, 16'h0888},
        '{4'h2, 3'h0, 16'h0888, 3'h0, 16'h0888}, '{4'h3, 3'h0, 16'h4654, 3'h4, 16'h0210},
        '{4'h4, 3'h2, 16'h1544, 3'h2, 16'h1544}, '{4'h5, 3'h0, 16'h4765, 3'h4, 16'h1542},
        '{4'h6, 3'h0, 16'h4876, 3'h2, 16'h2654}, '{4'h7, 3'h1, 16'h3876, 3'h1, 16'h3876},
        '{4'h8, 3'h0, 16'h0000, 3'h0, 16'h0000}};
    logic       clk = 1'b0, rst_n = 1'b1, soft_reset = 1'b0, wp_n = 1'b1, hold_n = 1'b1;
    logic       pat_en = 1'b0, pat, pfz, ptop, ptop_e, perr, quad, wpa, hda;
    logic [3:0] read_cmd = 4'h0, dummy_idx = 4'h0, dum_s, dum_e, ds, de;
    logic [2:0] mode_s, mode_e, bp;
    logic [7:0] cfg, rd, ev;
    wire        sclk, cs_n, mosi, miso, oe;
    int         fail_count = 0;
    int         comparisons = 0;
    int         oe_edges = 0;
    sfl_host_model u_sfl_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    sfl_config u_sfl_config (.ref_clk_i(clk), .reset_n_i(rst_n), .soft_reset_i(soft_reset),
        .sclk_i(sclk), .cs_n_i(cs_n), .data_line_zero_i(mosi), .data_line_one_o(miso),
        .data_line_one_oe_o(oe), .wp_n_i(wp_n), .hold_n_i(hold_n), .read_cmd_i(read_cmd),
        .ddr_learning_pattern_i(pat_en), .dummy_index_i(dummy_idx), .mode_cycles_o(mode_s),
        .dummy_cycles_o(dum_s), .pattern_drive_o(pat), .config_reg_one_o(cfg),
        .block_protect_bits_o(bp), .protect_from_zero_o(pfz), .param_at_top_o(ptop),
        .program_error_o(perr), .quad_mode_o(quad), .wp_active_o(wpa), .hold_active_o(hda));
    sfl_config #(.ENHANCED(1'b1), .UNIFORM(1'b1)) u_sfl_config_enh (.ref_clk_i(clk),
        .reset_n_i(rst_n), .soft_reset_i(soft_reset), .sclk_i(sclk), .cs_n_i(cs_n),
        .data_line_zero_i(mosi), .data_line_one_o(), .data_line_one_oe_o(), .wp_n_i(wp_n),
        .hold_n_i(hold_n), .read_cmd_i(read_cmd), .ddr_learning_pattern_i(pat_en),
        .dummy_index_i(dummy_idx), .mode_cycles_o(mode_e), .dummy_cycles_o(dum_e),
        .pattern_drive_o(), .config_reg_one_o(), .block_protect_bits_o(),
        .protect_from_zero_o(), .param_at_top_o(ptop_e), .program_error_o(), .quad_mode_o(),
        .wp_active_o(), .hold_active_o());
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        forever #2.5 clk = ~clk;
    end
    // serial edges at which the device drives its output line
    always @(posedge sclk) begin
        if (oe === 1'b1) begin
            oe_edges++;
        end
    end
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial begin
        // a real falling edge, so the serial-clock logic is reset as well
        #1 rst_n = 1'b0;
        step(16);
        rst_n = 1'b1;
        `CHECK("config at reset", `SFL_CR1_RESET, cfg)
        `CHECK("protect at reset", `SFL_BP_RESET, bp)
        u_sfl_host_model.read_cfg(rd);
        for (int c = 0; c < 4; c++) begin
            ev = {c[1:0], 6'h00};
            u_sfl_host_model.write_regs(8'h00, ev);
            u_sfl_host_model.read_cfg(rd);
            `CHECK("readback", ev, rd)
            foreach (rows[r]) begin
                ds = rows[r].ds[4 * c +: 4];
                de = rows[r].de[4 * c +: 4];
                step(1);
                read_cmd = rows[r].cmd;
                pat_en = 1'b1;
                dummy_idx = ds - 4'h1;
                #1;
                `CHECK("mode", rows[r].ms, mode_s)
                `CHECK("dummy", ds, dum_s)
                `CHECK("mode enhanced", rows[r].me, mode_e)
                `CHECK("dummy enhanced", de, dum_e)
                `CHECK("pattern", (ds >= 4'h5), pat)
            end
        end
        // five read frames, each driven for the eight edges after the opcode
        `CHECK("oe edges", 40, oe_edges)
        step(1);
        wp_n = 1'b0;
        hold_n = 1'b0;
        step(4);
        `CHECK("wp active", 1'b1, wpa)
        `CHECK("hold active", 1'b1, hda)
        wp_n = 1'b1;
        hold_n = 1'b1;
        u_sfl_host_model.write_regs(8'h00, 8'h02);
        `CHECK("quad", 1'b1, quad)
        step(1);
        wp_n = 1'b0;
        hold_n = 1'b0;
        step(4);
        `CHECK("wp in quad", 1'b0, wpa)
        `CHECK("hold in quad", 1'b0, hda)
        // placement bits chosen once, before any array work
        u_sfl_host_model.write_regs(8'h08, 8'h2E);
        `CHECK("protect bits", 3'h2, bp)
        `CHECK("from zero", 1'b1, pfz)
        `CHECK("param top", 1'b1, ptop)
        `CHECK("param uniform", 1'b0, ptop_e)
        u_sfl_host_model.write_regs(8'h08, 8'h12);
        `CHECK("one-time sticky", 8'h2E, cfg)
        `CHECK("program error", 1'b1, perr)
        step(1);
        soft_reset = 1'b1;
        step(2);
        soft_reset = 1'b0;
        step(4);
        `CHECK("volatile reload", 3'h7, bp)
        u_sfl_host_model.write_regs(8'h1C, 8'hAF);
        `CHECK("freeze with code", 8'hAF, cfg)
        u_sfl_host_model.write_regs(8'h00, 8'h2E);
        `CHECK("protect frozen", 3'h7, bp)
        `CHECK("freeze kept", 8'h2F, cfg)
        step(1);
        soft_reset = 1'b1;
        step(2);
        soft_reset = 1'b0;
        step(4);
        `CHECK("freeze after soft reset", 1'b1, cfg[0])
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(2);
        `CHECK("freeze after reset", 1'b0, cfg[0])
        print_verdict();
    end
endmodule : sfl_config_test
`default_nettype wire
